// ===== rtl/dgt_pkg.sv
/*
 * dgt_pkg: register map, field layout, reset values and bus carrier for
 * the dual general timer block.
 * Assumes one 100 MHz core clock and a plain strobe register port.
 */
package dgt_pkg;
   // register byte offsets on the 8-bit register address
   localparam logic [7:0] DGT_T0_RELOAD_OFF = 8'h00;
   localparam logic [7:0] DGT_T0_COUNT_OFF = 8'h04;
   localparam logic [7:0] DGT_T0_CTRL_OFF = 8'h08;
   localparam logic [7:0] DGT_T0_CLR_OFF = 8'h0C;
   localparam logic [7:0] DGT_T1_RELOAD_OFF = 8'h20;
   localparam logic [7:0] DGT_T1_COUNT_OFF = 8'h24;
   localparam logic [7:0] DGT_T1_CTRL_OFF = 8'h28;
   localparam logic [7:0] DGT_T1_CLR_OFF = 8'h2C;
   localparam logic [7:0] DGT_T1_SNAP_OFF = 8'h30;

   // control field positions, shared by both timers where they coincide
   localparam int DGT_EN_BIT = 7;
   localparam int DGT_PERIODIC_BIT = 6;
   localparam int DGT_T0_PRE_LSB = 2;
   localparam int DGT_T1_UP_BIT = 8;
   localparam int DGT_T1_FMT_LSB = 4;
   localparam int DGT_T1_PRE_LSB = 0;
   localparam int DGT_T1_SRC_LSB = 9;
   localparam int DGT_T1_EVT_LSB = 12;
   localparam int DGT_T1_CAP_BIT = 17;
   localparam int DGT_EVT_OFFSET = 2;

   // writable bits of each control word; reserved bits read zero
   localparam logic [31:0] DGT_T0_CTRL_MASK = 32'h0000_00CC;
   localparam logic [31:0] DGT_T1_CTRL_MASK = 32'h0003_FFFF;
   localparam logic [31:0] DGT_CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] DGT_T0_MAX = 16'hFFFF;
   localparam logic [31:0] DGT_T1_MAX = 32'hFFFF_FFFF;

   // prescale codes
   localparam logic [1:0] DGT_T0_DIV16 = 2'h1;
   localparam logic [1:0] DGT_T0_DIV256 = 2'h2;
   localparam logic [3:0] DGT_T1_DIV16 = 4'h4;
   localparam logic [3:0] DGT_T1_DIV256 = 4'h8;
   localparam logic [3:0] DGT_T1_DIV32768 = 4'hF;

   // time format limits, one byte per field
   localparam logic [7:0] DGT_HUND_MAX = 8'h63;
   localparam logic [7:0] DGT_SEC_MAX = 8'h3B;
   localparam logic [7:0] DGT_HR23_MAX = 8'h17;
   localparam logic [7:0] DGT_HR255_MAX = 8'hFF;

   typedef enum logic [1:0] {DGT_FMT_BIN, DGT_FMT_RSVD, DGT_FMT_HR23, DGT_FMT_HR255} dgt_fmt_t;
   typedef enum logic [2:0] {DGT_SRC_CORE, DGT_SRC_OSC, DGT_SRC_EXT_A, DGT_SRC_EXT_B,
                             DGT_SRC_NONE4, DGT_SRC_NONE5, DGT_SRC_NONE6,
                             DGT_SRC_NONE7} dgt_src_t;

   // one register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } dgt_bus_t;
endpackage

// ===== rtl/dgt_timers.sv
/*
 * dgt_timers: a 16-bit down-counting tick timer and a 32-bit up/down
 * capture timer with binary or h:m:s:hundredths format.
 * Assumes ref_clk at 100 MHz, a master that never waits, interrupt sources
 * on the same clock, and asynchronous oscillator and count pins.
 */
// Added by the designer: strobed register access and the address map.
// Contract
// - free-running restarts at max or min
// - periodic restarts from reload register
// - count readable without disturbing counting
// - control write with enable starts timer
// - interrupt at zero or full scale
// - any write to clear drops interrupt; a terminal count in the same cycle keeps it set instead
// - rtos_tick_counter 16-bit down, core clock prescaled
// - rtos_tick_counter reload/count 16 bits, count read-only
// - rtos_tick_counter bit7 enable, bit6 periodic, reset zero
// - rtos_tick_counter prescale 1,16,256; code 11 as 00
// - general_capture_counter 32-bit up/down, selectable prescaled source
// - general_capture_counter source select bits 11-9
// - general_capture_counter bit8 up, down by default
// - general_capture_counter bit7 enable, bit6 periodic
// - general_capture_counter format binary or time
// - general_capture_counter prescale 1,16,256,32768
// - general_capture_counter bit17 enables capture
// - event select offset by two
// - first assertion of event captures count
// - general_capture_counter registers 32 bits, read-only ones
// - general_capture_counter drives conversion start trigger
`timescale 1ns/1ps
module dgt_timers (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire dgt_pkg::dgt_bus_t bus,
   output logic [31:0] bus_rdata,
   input wire logic osc_32k,
   input wire logic ext_count_input_a,
   input wire logic ext_count_input_b,
   input wire logic [31:0] irq_sources,
   output logic t0_irq,
   output logic t1_irq,
   output logic adc_trigger
);
   import dgt_pkg::*;

   // one h:m:s:hundredths step, each field held in its own byte
   function automatic logic [31:0] tm_step(input logic [31:0] v, input logic up,
                                           input logic [7:0] hmax);
      logic [7:0] h;
      logic [7:0] m;
      logic [7:0] s;
      logic [7:0] c;
      logic carry;
      h = v[31:24];
      m = v[23:16];
      s = v[15:8];
      c = v[7:0];
      if (up) begin
         carry = (c >= DGT_HUND_MAX);
         c = carry ? 8'h00 : c + 8'h01;
         if (carry) begin
            carry = (s >= DGT_SEC_MAX);
            s = carry ? 8'h00 : s + 8'h01;
         end
         if (carry) begin
            carry = (m >= DGT_SEC_MAX);
            m = carry ? 8'h00 : m + 8'h01;
         end
         if (carry) begin
            h = (h >= hmax) ? 8'h00 : h + 8'h01;
         end
      end else begin
         carry = (c == 8'h00);
         c = carry ? DGT_HUND_MAX : c - 8'h01;
         if (carry) begin
            carry = (s == 8'h00);
            s = carry ? DGT_SEC_MAX : s - 8'h01;
         end
         if (carry) begin
            carry = (m == 8'h00);
            m = carry ? DGT_SEC_MAX : m - 8'h01;
         end
         if (carry) begin
            h = (h == 8'h00) ? hmax : h - 8'h01;
         end
      end
      return {h, m, s, c};
   endfunction

   // full scale of general_capture_counter for a given control word
   function automatic logic [31:0] t1_full(input logic [31:0] ctrl);
      logic [1:0] f;
      f = ctrl[DGT_T1_FMT_LSB +: 2];
      case (f)
         DGT_FMT_HR23: return {DGT_HR23_MAX, DGT_SEC_MAX, DGT_SEC_MAX, DGT_HUND_MAX};
         DGT_FMT_HR255: return {DGT_HR255_MAX, DGT_SEC_MAX, DGT_SEC_MAX, DGT_HUND_MAX};
         default: return DGT_T1_MAX; // binary, reserved code treated as binary
      endcase
   endfunction

   // value general_capture_counter starts or restarts from
   function automatic logic [31:0] t1_begin(input logic [31:0] ctrl, input logic [31:0] rl);
      if (ctrl[DGT_PERIODIC_BIT]) begin
         return rl;
      end
      return ctrl[DGT_T1_UP_BIT] ? 32'h0000_0000 : t1_full(ctrl);
   endfunction

   logic [15:0] t0_reload_value;
   logic [15:0] t0_current_count;
   logic [31:0] t0_control;
   logic [7:0] t0_pre;
   logic [31:0] t1_reload_value;
   logic [31:0] t1_current_count;
   logic [31:0] t1_control;
   logic [31:0] t1_event_snapshot;
   logic [14:0] t1_pre;
   logic [2:0] pin_s1;
   logic [2:0] pin_s2;
   logic [2:0] pin_s3;
   logic evt_prev;
   logic [31:0] next_rdata;

   // register port decode
   wire wr_t0_reload = bus.wr && (bus.addr == DGT_T0_RELOAD_OFF);
   wire wr_t0_ctrl = bus.wr && (bus.addr == DGT_T0_CTRL_OFF);
   wire wr_t0_clr = bus.wr && (bus.addr == DGT_T0_CLR_OFF);
   wire wr_t1_reload = bus.wr && (bus.addr == DGT_T1_RELOAD_OFF);
   wire wr_t1_ctrl = bus.wr && (bus.addr == DGT_T1_CTRL_OFF);
   wire wr_t1_clr = bus.wr && (bus.addr == DGT_T1_CLR_OFF);
   wire [31:0] t0_ctrl_in = bus.wdata & DGT_T0_CTRL_MASK;
   wire [31:0] t1_ctrl_in = bus.wdata & DGT_T1_CTRL_MASK;

   // pin synchronisers; stage three only feeds the edge detect
   wire [2:0] pin_raw = {ext_count_input_b, ext_count_input_a, osc_32k};
   wire [2:0] pin_rise = pin_s2 & ~pin_s3;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               pin_s1[gi] <= 1'b0;
               pin_s2[gi] <= 1'b0;
               pin_s3[gi] <= 1'b0;
            end else begin
               pin_s1[gi] <= pin_raw[gi];
               pin_s2[gi] <= pin_s1[gi];
               pin_s3[gi] <= pin_s2[gi];
            end
         end
      end
   endgenerate

   // rtos_tick_counter prescaler; code 11 falls back to divide by one
   wire t0_en = t0_control[DGT_EN_BIT];
   wire [1:0] t0_pcode = t0_control[DGT_T0_PRE_LSB +: 2];
   wire [7:0] t0_pmask = (t0_pcode == DGT_T0_DIV16) ? 8'h0F :
                         (t0_pcode == DGT_T0_DIV256) ? 8'hFF : 8'h00;
   wire t0_tick = t0_en && ((t0_pre & t0_pmask) == t0_pmask);
   wire [15:0] t0_start = t0_control[DGT_PERIODIC_BIT] ? t0_reload_value : DGT_T0_MAX;
   // terminal count restarts, otherwise one step down
   wire [15:0] next_t0_count = (t0_current_count == 16'h0000) ? t0_start :
                               t0_current_count - 16'h0001;
   // a control write loads or holds instead of stepping, so it never counts as a hit
   wire t0_hit = t0_tick && !wr_t0_ctrl && (next_t0_count == 16'h0000);

   // general_capture_counter source select and prescaler
   wire t1_en = t1_control[DGT_EN_BIT];
   wire t1_up = t1_control[DGT_T1_UP_BIT];
   wire [2:0] t1_src = t1_control[DGT_T1_SRC_LSB +: 3];
   wire [3:0] t1_pcode = t1_control[DGT_T1_PRE_LSB +: 4];
   wire src_pulse = (t1_src == DGT_SRC_CORE) ? 1'b1 :
                    (t1_src == DGT_SRC_OSC) ? pin_rise[0] :
                    (t1_src == DGT_SRC_EXT_A) ? pin_rise[1] :
                    (t1_src == DGT_SRC_EXT_B) ? pin_rise[2] : 1'b0;
   // undefined prescale codes act as divide by one
   wire [14:0] t1_pmask = (t1_pcode == DGT_T1_DIV16) ? 15'h000F :
                          (t1_pcode == DGT_T1_DIV256) ? 15'h00FF :
                          (t1_pcode == DGT_T1_DIV32768) ? 15'h7FFF : 15'h0000;
   wire t1_src_en = t1_en && src_pulse;
   wire t1_tick = t1_src_en && ((t1_pre & t1_pmask) == t1_pmask);
   wire [1:0] t1_fmt = t1_control[DGT_T1_FMT_LSB +: 2];
   wire t1_timefmt = t1_fmt[1];
   wire [31:0] t1_fs = t1_full(t1_control);
   wire [31:0] t1_term = t1_up ? t1_fs : 32'h0000_0000;
   wire [31:0] t1_stepped = t1_timefmt ?
                            tm_step(t1_current_count, t1_up, t1_fs[31:24]) :
                            (t1_up ? t1_current_count + 32'h1 :
                             t1_current_count - 32'h1);
   wire [31:0] next_t1_count = (t1_current_count == t1_term) ?
                               t1_begin(t1_control, t1_reload_value) : t1_stepped;
   wire t1_hit = t1_tick && !wr_t1_ctrl && (next_t1_count == t1_term);

   // capture event; selected index sits two above the field
   wire [5:0] evt_idx = {1'b0, t1_control[DGT_T1_EVT_LSB +: 5]} + 6'(DGT_EVT_OFFSET);
   wire evt_level = (evt_idx < 6'h20) ? irq_sources[evt_idx[4:0]] : 1'b0;
   wire cap_fire = t1_control[DGT_T1_CAP_BIT] && evt_level && !evt_prev;

   // control and reload registers; reserved bits are never stored
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         t0_control <= DGT_CTRL_RESET;
         t1_control <= DGT_CTRL_RESET;
         t0_reload_value <= 16'h0000;
         t1_reload_value <= 32'h0000_0000;
      end else begin
         if (wr_t0_ctrl) t0_control <= t0_ctrl_in;
         if (wr_t1_ctrl) t1_control <= t1_ctrl_in;
         if (wr_t0_reload) t0_reload_value <= bus.wdata[15:0];
         if (wr_t1_reload) t1_reload_value <= bus.wdata;
      end
   end

   // rtos_tick_counter counter; a control write with enable set (re)starts it
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         t0_current_count <= 16'h0000;
         t0_pre <= 8'h00;
      end else if (wr_t0_ctrl) begin
         t0_pre <= 8'h00;
         if (t0_ctrl_in[DGT_EN_BIT]) begin
            t0_current_count <= t0_ctrl_in[DGT_PERIODIC_BIT] ? t0_reload_value : DGT_T0_MAX;
         end
      end else if (t0_en) begin
         t0_pre <= t0_pre + 8'h01;
         if (t0_tick) t0_current_count <= next_t0_count;
      end
   end

   // general_capture_counter counter; prescaler only advances on source pulses
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         t1_current_count <= 32'h0000_0000;
         t1_pre <= 15'h0000;
      end else if (wr_t1_ctrl) begin
         t1_pre <= 15'h0000;
         if (t1_ctrl_in[DGT_EN_BIT]) begin
            t1_current_count <= t1_begin(t1_ctrl_in, t1_reload_value);
         end
      end else if (t1_src_en) begin
         t1_pre <= t1_pre + 15'h0001;
         if (t1_tick) t1_current_count <= next_t1_count;
      end
   end

   // pending flags; a terminal count in the clear cycle still sets
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         t0_irq <= 1'b0;
         t1_irq <= 1'b0;
         adc_trigger <= 1'b0;
      end else begin
         t0_irq <= t0_hit || (t0_irq && !wr_t0_clr);
         t1_irq <= t1_hit || (t1_irq && !wr_t1_clr);
         adc_trigger <= t1_hit;
      end
   end

   // capture on the first cycle of the selected source; level held ignored
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         evt_prev <= 1'b0;
         t1_event_snapshot <= 32'h0000_0000;
      end else begin
         evt_prev <= evt_level;
         if (cap_fire) t1_event_snapshot <= t1_current_count;
      end
   end

   // read mux: pure selection, so reads never touch counter state
   always_comb begin
      case (bus.addr)
         DGT_T0_RELOAD_OFF: next_rdata = {16'h0000, t0_reload_value};
         DGT_T0_COUNT_OFF: next_rdata = {16'h0000, t0_current_count};
         DGT_T0_CTRL_OFF: next_rdata = t0_control;
         DGT_T1_RELOAD_OFF: next_rdata = t1_reload_value;
         DGT_T1_COUNT_OFF: next_rdata = t1_current_count;
         DGT_T1_CTRL_OFF: next_rdata = t1_control;
         DGT_T1_SNAP_OFF: next_rdata = t1_event_snapshot;
         default: next_rdata = 32'h0000_0000; // clear registers and holes read zero
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_rdata <= 32'h0000_0000;
      end else begin
         bus_rdata <= bus.rd ? next_rdata : 32'h0000_0000;
      end
   end

   // checks kept beside the logic they guard
   a_t0_clear_irq: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_t0_clr && !t0_hit |=> !t0_irq)
      else $error("rtos_tick_counter interrupt not cleared by write");

   a_t0_hit_irq: assert property (@(posedge ref_clk) disable iff (!arst_n)
      t0_tick && !wr_t0_ctrl && (t0_current_count == 16'h0001) |=> t0_irq && (t0_current_count == 16'h0000))
      else $error("rtos_tick_counter reached zero without interrupt");

   a_t0_periodic_reload: assert property (@(posedge ref_clk) disable iff (!arst_n)
      t0_tick && !wr_t0_ctrl && t0_control[DGT_PERIODIC_BIT] && !wr_t0_reload &&
      (t0_current_count == 16'h0000) |=> t0_current_count == $past(t0_reload_value))
      else $error("rtos_tick_counter periodic reload wrong");

   a_t0_free_wrap: assert property (@(posedge ref_clk) disable iff (!arst_n)
      t0_tick && !wr_t0_ctrl && !t0_control[DGT_PERIODIC_BIT] &&
      (t0_current_count == 16'h0000) |=> t0_current_count == 16'hFFFF)
      else $error("rtos_tick_counter free-running wrap wrong");

   a_t0_prescale_sixteen: assert property (@(posedge ref_clk) disable iff (!arst_n)
      t0_tick && (t0_pcode == DGT_T0_DIV16) |-> t0_pre[3:0] == 4'hF)
      else $error("rtos_tick_counter divide by 16 ticks early");

   a_count_read_back: assert property (@(posedge ref_clk) disable iff (!arst_n)
      bus.rd && (bus.addr == DGT_T1_COUNT_OFF) |=> bus_rdata == $past(t1_current_count))
      else $error("general_capture_counter count read back wrong");

   a_t1_holds_disabled: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !t1_en && !wr_t1_ctrl |=> $stable(t1_current_count))
      else $error("general_capture_counter moved while disabled");

   a_t1_binary_up: assert property (@(posedge ref_clk) disable iff (!arst_n)
      t1_tick && !wr_t1_ctrl && t1_up && !t1_timefmt &&
      (t1_current_count != DGT_T1_MAX) |=> t1_current_count == $past(t1_current_count) + 32'h1)
      else $error("general_capture_counter binary up step wrong");

   a_t1_capture_value: assert property (@(posedge ref_clk) disable iff (!arst_n)
      cap_fire |=> t1_event_snapshot == $past(t1_current_count))
      else $error("general_capture_counter capture missed");

   a_t1_adc_trigger: assert property (@(posedge ref_clk) disable iff (!arst_n)
      t1_hit |=> adc_trigger && t1_irq)
      else $error("conversion trigger missing at terminal count");

   a_t1_adc_single: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !t1_hit |=> !adc_trigger)
      else $error("conversion trigger without terminal count");

   a_t1_clear_irq: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_t1_clr && !t1_hit |=> !t1_irq)
      else $error("general_capture_counter interrupt not cleared by write");

   a_t0_holds_disabled: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !t0_en && !wr_t0_ctrl |=> $stable(t0_current_count))
      else $error("rtos_tick_counter moved while disabled");

   a_t0_free_start: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_t0_ctrl && bus.wdata[DGT_EN_BIT] && !bus.wdata[DGT_PERIODIC_BIT] |=>
      t0_current_count == DGT_T0_MAX)
      else $error("rtos_tick_counter free start value wrong");

   a_t0_count_read: assert property (@(posedge ref_clk) disable iff (!arst_n)
      bus.rd && (bus.addr == DGT_T0_COUNT_OFF) |=>
      bus_rdata == {16'h0000, $past(t0_current_count)})
      else $error("rtos_tick_counter count read back wrong");

   a_t1_binary_down: assert property (@(posedge ref_clk) disable iff (!arst_n)
      t1_tick && !wr_t1_ctrl && !t1_up && !t1_timefmt && (t1_current_count != 32'h0000_0000)
      |=> t1_current_count == $past(t1_current_count) - 32'h1)
      else $error("general_capture_counter binary down step wrong");

   a_t1_up_wrap: assert property (@(posedge ref_clk) disable iff (!arst_n)
      t1_tick && !wr_t1_ctrl && t1_up && !t1_control[DGT_PERIODIC_BIT] &&
      (t1_current_count == t1_term) |=> t1_current_count == 32'h0000_0000)
      else $error("general_capture_counter free-running up wrap wrong");

   a_t1_periodic_reload: assert property (@(posedge ref_clk) disable iff (!arst_n)
      t1_tick && !wr_t1_ctrl && t1_control[DGT_PERIODIC_BIT] &&
      (t1_current_count == t1_term) |=> t1_current_count == $past(t1_reload_value))
      else $error("general_capture_counter periodic reload wrong");

   a_t1_hund_rollover: assert property (@(posedge ref_clk) disable iff (!arst_n)
      t1_tick && !wr_t1_ctrl && t1_up && t1_timefmt && (t1_current_count != t1_term) &&
      (t1_current_count[7:0] == DGT_HUND_MAX) |=> t1_current_count[7:0] == 8'h00)
      else $error("general_capture_counter hundredths rollover wrong");

   a_t1_prescale_max: assert property (@(posedge ref_clk) disable iff (!arst_n)
      t1_tick && (t1_pcode == DGT_T1_DIV32768) |-> t1_pre == 15'h7FFF)
      else $error("general_capture_counter divide by 32768 ticks early");

   a_t1_src_none: assert property (@(posedge ref_clk) disable iff (!arst_n)
      t1_en && t1_src[2] && !wr_t1_ctrl |=> $stable(t1_current_count))
      else $error("general_capture_counter moved with no source selected");

   a_snap_holds: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !cap_fire |=> $stable(t1_event_snapshot))
      else $error("general_capture_counter snapshot changed without event");
endmodule // dgt_timers

// ===== dv/dgt_timers_tb_top.sv
/*
 * dgt_timers_tb_top: self-checking bench for the dual general timer block.
 * Assumes dgt_pkg and dgt_timers are compiled first; the bench drives every
 * port itself, count pins and interrupt sources included.
 */
`timescale 1ns/1ps
module dgt_timers_tb_top;
   import dgt_pkg::*;
   logic ref_clk;
   logic arst_n;
   dgt_bus_t bus;
   logic [31:0] bus_rdata;
   logic osc_32k;
   logic ext_count_input_a;
   logic ext_count_input_b;
   logic [31:0] irq_sources;
   logic t0_irq;
   logic t1_irq;
   logic adc_trigger;
   int err_count;
   int samples_checked;
   int e;
   logic [31:0] seed;
   logic [31:0] rd_val;
   logic [31:0] r0;
   logic [31:0] r1;
   // places that read zero after reset, unmapped ones among them
   localparam logic [7:0] ZERO_ADDR [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20, 8'h24, 8'h28,
                                            8'h2C, 8'h30, 8'h40, 8'hFC};
   localparam int T0_DIV [4] = '{1, 16, 256, 1};
   // general_capture_counter prescale cases: code, reload, irq period in cycles
   localparam logic [3:0] T1_PRE [5] = '{4'h0, 4'h4, 4'h8, 4'hF, 4'h3};
   localparam logic [31:0] T1_LOAD [5] = '{32'hFFFF_FFFC, 32'hFFFF_FFFE, 32'hFFFF_FFFE,
                                          32'hFFFF_FFFF, 32'hFFFF_FFFC};
   localparam int T1_PER [5] = '{4, 32, 512, 32768, 4};
   // format cases: control, reload, count after one step
   localparam logic [31:0] FMT_CTRL [7] = '{32'h0E0, 32'h0A0, 32'h0B0, 32'h1F0, 32'h1A0,
                                           32'h080, 32'h1D0};
   localparam logic [31:0] FMT_LOAD [7] = '{32'h0001_0000, 32'h0, 32'h0, 32'h173B_3B63, 32'h0,
                                           32'h0, 32'h0000_FFFF};
   localparam logic [31:0] FMT_EXP [7] = '{32'h0000_3B63, 32'h173B_3B62, 32'hFF3B_3B62,
                                          32'h1800_0000, 32'h0000_0001, 32'hFFFF_FFFE,
                                          32'h0001_0000};

   dgt_timers dgt_timers_i (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .bus(bus),
      .bus_rdata(bus_rdata),
      .osc_32k(osc_32k),
      .ext_count_input_a(ext_count_input_a),
      .ext_count_input_b(ext_count_input_b),
      .irq_sources(irq_sources),
      .t0_irq(t0_irq),
      .t1_irq(t1_irq),
      .adc_trigger(adc_trigger)
   );

   // 100 MHz core clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one-cycle write strobe, released at the edge that takes it
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus <= '0;
   endtask

   // read data only stands in the cycle after the strobe: sample mid-cycle
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus <= '0;
      @(negedge ref_clk);
      check(bus_rdata, exp);
   endtask

   task automatic wait_irq(input bit sel, input int lim);
      int n;
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while ((sel ? t1_irq : t0_irq) !== 1'b1 && n < lim);
      if (n >= lim) begin
         err_count++;
         $display("mismatch at %0t: interrupt never came", $time);
      end
   endtask

   // clears, waits for a rise, clears again, times the next rise
   task automatic measure(input bit sel, input int period);
      longint t_a;
      bus_wr(sel ? DGT_T1_CLR_OFF : DGT_T0_CLR_OFF, xs());
      wait_irq(sel, period + 40000);
      t_a = $time;
      if (sel)
         check(32'(adc_trigger), 32'h1);
      bus_wr(sel ? DGT_T1_CLR_OFF : DGT_T0_CLR_OFF, xs());
      @(negedge ref_clk);
      check(32'(sel ? t1_irq : t0_irq), 32'h0);
      wait_irq(sel, period + 8);
      check(32'(($time - t_a) / 10), 32'(period));
   endtask

   task automatic pin(input int s, input logic v);
      @(posedge ref_clk);
      case (s)
         1: osc_32k <= v;
         2: ext_count_input_a <= v;
         default: ext_count_input_b <= v;
      endcase
      repeat (6) @(posedge ref_clk);
   endtask

   task automatic pulse_src(input int b);
      @(posedge ref_clk);
      irq_sources[b] <= 1'b1;
      repeat (2) @(posedge ref_clk);
      irq_sources[b] <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // watchdog: the whole run needs about 75k cycles, the slowest case most of it
   initial begin
      #900_000;
      err_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      finish_test();
   end

   initial begin
      err_count = 0;
      samples_checked = 0;
      seed = 32'hFD4A;
      arst_n = 1'b0;
      bus = '0;
      osc_32k = 1'b0;
      ext_count_input_a = 1'b0;
      ext_count_input_b = 1'b0;
      irq_sources = '0;
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      // reset values; clear and unmapped places read zero
      foreach (ZERO_ADDR[i])
         rd_chk(ZERO_ADDR[i], 32'h0);
      // reload written but timer not enabled: counts stay put
      r0 = xs();
      r1 = xs();
      bus_wr(DGT_T0_RELOAD_OFF, r0);
      bus_wr(DGT_T1_RELOAD_OFF, r1);
      bus_wr(DGT_T0_CTRL_OFF, 32'h4C);
      rd_chk(DGT_T0_RELOAD_OFF, {16'h0, r0[15:0]});
      rd_chk(DGT_T1_RELOAD_OFF, r1);
      rd_chk(DGT_T0_COUNT_OFF, 32'h0);
      rd_chk(DGT_T1_COUNT_OFF, 32'h0);
      // reserved control bits read zero
      r0 = xs();
      bus_wr(DGT_T0_CTRL_OFF, r0);
      rd_chk(DGT_T0_CTRL_OFF, r0 & 32'h0000_00CC);
      r1 = xs();
      bus_wr(DGT_T1_CTRL_OFF, r1);
      rd_chk(DGT_T1_CTRL_OFF, r1 & 32'h0003_FFFF);
      // rtos_tick_counter free start, then periodic at every prescale code
      bus_wr(DGT_T0_CTRL_OFF, 32'h80);
      rd_chk(DGT_T0_COUNT_OFF, 32'h0000_FFFE);
      foreach (T0_DIV[i]) begin
         r0 = (xs() % 8) + 32'h3;
         bus_wr(DGT_T0_RELOAD_OFF, r0);
         bus_wr(DGT_T0_CTRL_OFF, 32'h0C0 | 32'(i << 2));
         measure(1'b0, int'(r0 + 1) * T0_DIV[i]);
      end
      bus_wr(DGT_T0_CTRL_OFF, 32'h0);
      // general_capture_counter counting up to full scale at each defined prescale code and at undefined code 3
      foreach (T1_PRE[i]) begin
         bus_wr(DGT_T1_RELOAD_OFF, T1_LOAD[i]);
         bus_wr(DGT_T1_CTRL_OFF, 32'h1C0 | 32'(T1_PRE[i]));
         measure(1'b1, T1_PER[i]);
      end
      // format, direction and start values, read while running
      foreach (FMT_CTRL[i]) begin
         bus_wr(DGT_T1_RELOAD_OFF, FMT_LOAD[i]);
         bus_wr(DGT_T1_CTRL_OFF, FMT_CTRL[i]);
         rd_chk(DGT_T1_COUNT_OFF, FMT_EXP[i]);
      end
      // oscillator and both pins as count sources, two steps to full scale
      for (int s = 1; s <= 3; s++) begin
         bus_wr(DGT_T1_RELOAD_OFF, 32'hFFFF_FFFD);
         bus_wr(DGT_T1_CTRL_OFF, 32'h1C0 | 32'(s << 9));
         bus_wr(DGT_T1_CLR_OFF, xs());
         pin(s, 1'b1);
         pin(s, 1'b0);
         check(32'(t1_irq), 32'h0);
         pin(s, 1'b1);
         pin(s, 1'b0);
         check(32'(t1_irq), 32'h1);
      end
      // capture on a source with no clock, so the count holds still
      e = int'(xs() % 29);
      r0 = xs();
      r1 = xs();
      bus_wr(DGT_T1_RELOAD_OFF, r0);
      bus_wr(DGT_T1_CTRL_OFF, 32'h2_08C0 | 32'(e << 12));
      pulse_src(e + 3);
      rd_chk(DGT_T1_SNAP_OFF, 32'h0);
      pulse_src(e + 2);
      rd_chk(DGT_T1_SNAP_OFF, r0);
      bus_wr(DGT_T1_COUNT_OFF, ~r0);
      bus_wr(DGT_T1_SNAP_OFF, ~r0);
      rd_chk(DGT_T1_COUNT_OFF, r0);
      rd_chk(DGT_T1_SNAP_OFF, r0);
      bus_wr(DGT_T1_RELOAD_OFF, r1);
      bus_wr(DGT_T1_CTRL_OFF, 32'h0_08C0 | 32'(e << 12));
      pulse_src(e + 2);
      rd_chk(DGT_T1_SNAP_OFF, r0);
      rd_chk(DGT_T1_COUNT_OFF, r1);
      bus_wr(DGT_T1_CTRL_OFF, 32'h2_08C0 | 32'(e << 12));
      pulse_src(e + 2);
      rd_chk(DGT_T1_SNAP_OFF, r1);
      finish_test();
   end
endmodule // dgt_timers_tb_top
